//--- core/vdoc_top.sv
// Purpose: voltage dependent definite-time overcurrent decision
// Assumes: magnitudes arrive synchronous to core_clk, settings via register port
// Notes: trip delay counts core_clk cycles
`timescale 1ns/1ps
module vdoc_top
  import vdoc_pkg::*;
#(
  parameter int W = 16
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // measurements
  input wire logic [W-1:0] cur_l1,
  input wire logic [W-1:0] cur_l2,
  input wire logic [W-1:0] cur_l3,
  input wire logic [W-1:0] volt_l12,
  input wire logic [W-1:0] volt_l23,
  input wire logic [W-1:0] volt_l31,
  // blocking
  input wire logic user_block,
  input wire logic vts_block,
  // decisions
  output logic [2:0] start_ph,
  output logic gen_start,
  output logic gen_trip,
  output logic setting_err,
  output logic irq
);

  initial begin
    if (W < 4 || W > 30) begin
      $error("vdoc_top: W must be 4..30");
    end
  end

  typedef struct packed {
    logic en;
    logic mode;
    logic [W-1:0] pickup;
    logic [W-1:0] u_low;
    logic [W-1:0] u_high;
    logic [7:0] floor_pct;
    logic [31:0] delay;
    logic [2:0][31:0] cnt;
    logic [2:0] start;
    logic [2:0] trip_ph;
    logic trip;
    logic gstart;
    logic err;
    logic [VDOC_IRQ_W-1:0] irq_stat;
    logic [VDOC_IRQ_W-1:0] irq_en;
    logic irq;
    logic [31:0] rdata;
  } vdoc_state_t;

  vdoc_state_t s_q;
  vdoc_state_t s_d;

  // floor threshold, limited so the slope never turns negative
  function automatic logic [W-1:0] floor_of(input logic [W-1:0] pk, input logic [7:0] pct);
    logic [W+7:0] f;
    f = ((W+8)'(pk) * (W+8)'(pct)) / (W+8)'(VDOC_PERCENT);
    if (f > (W+8)'(pk)) begin
      floor_of = pk;
    end else begin
      floor_of = W'(f);
    end
  endfunction

  function automatic logic [31:0] zext(input logic [W-1:0] v);
    zext = 32'(v);
  endfunction

  logic [W-1:0] floor_thr;
  logic [2:0] cond;
  logic [W-1:0] cur [3];
  logic [W-1:0] volt [3];

  assign floor_thr = floor_of(s_q.pickup, s_q.floor_pct);
  assign cur[0] = cur_l1;
  assign cur[1] = cur_l2;
  assign cur[2] = cur_l3;
  // each current meets its own line-to-line voltage
  assign volt[0] = volt_l12;
  assign volt[1] = volt_l23;
  assign volt[2] = volt_l31;

  for (genvar p = 0; p < 3; p++) begin : g_ph
    vdoc_phase #(
      .W(W)
    ) u_phase (
      .mode(s_q.mode),
      .pickup(s_q.pickup),
      .floor_thr(floor_thr),
      .u_low(s_q.u_low),
      .u_high(s_q.u_high),
      .cur(cur[p]),
      .volt(volt[p]),
      .start_cond(cond[p])
    );
  end

  logic wr_hit;
  logic allowed;
  logic err_now;
  logic [VDOC_IRQ_W-1:0] ev;
  logic [VDOC_IRQ_W-1:0] clr;

  always_comb begin
    s_d = s_q;
    wr_hit = reg_wr && !reg_rd;
    clr = '0;

    // register writes
    if (wr_hit) begin
      case (reg_addr)
        VDOC_OFS_CTRL: begin
          s_d.en = reg_wdata[VDOC_CTRL_EN_BIT];
          s_d.mode = reg_wdata[VDOC_CTRL_MODE_BIT];
        end
        VDOC_OFS_PICKUP: s_d.pickup = reg_wdata[W-1:0];
        VDOC_OFS_ULOW: s_d.u_low = reg_wdata[W-1:0];
        VDOC_OFS_UHIGH: s_d.u_high = reg_wdata[W-1:0];
        VDOC_OFS_FLOOR: s_d.floor_pct = reg_wdata[7:0];
        VDOC_OFS_DELAY: s_d.delay = reg_wdata;
        VDOC_OFS_IRQ_EN: s_d.irq_en = reg_wdata[VDOC_IRQ_W-1:0];
        VDOC_OFS_IRQ_CLR: clr = reg_wdata[VDOC_IRQ_W-1:0];
        default: ;
      endcase
    end

    // the limit check follows the live settings, so a fixed load releases it
    err_now = (s_q.mode == VDOC_MODE_SCALED) && (s_q.u_low > s_q.u_high);
    s_d.err = err_now;
    allowed = s_q.en && !user_block && !vts_block && !err_now;

    for (int p = 0; p < 3; p++) begin
      s_d.start[p] = allowed && cond[p];
      if (s_d.start[p]) begin
        s_d.trip_ph[p] = s_q.cnt[p] >= s_q.delay;
        if (s_q.cnt[p] != 32'hFFFF_FFFF) begin
          s_d.cnt[p] = s_q.cnt[p] + 32'h0000_0001;
        end
      end else begin
        s_d.cnt[p] = 32'h0000_0000;
        s_d.trip_ph[p] = 1'b0;
      end
    end
    s_d.gstart = |s_d.start;
    s_d.trip = |s_d.trip_ph;

    // sticky events; a new event beats a clear in the same cycle
    ev = '0;
    ev[VDOC_EV_START_BIT] = s_d.gstart && !s_q.gstart;
    ev[VDOC_EV_TRIP_BIT] = s_d.trip && !s_q.trip;
    ev[VDOC_EV_ERR_BIT] = err_now && !s_q.err;
    s_d.irq_stat = (s_q.irq_stat & ~clr) | ev;
    s_d.irq = |(s_d.irq_stat & s_d.irq_en);

    // read data stand only in the cycle after the strobe
    s_d.rdata = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        VDOC_OFS_CTRL: begin
          s_d.rdata[VDOC_CTRL_EN_BIT] = s_q.en;
          s_d.rdata[VDOC_CTRL_MODE_BIT] = s_q.mode;
        end
        VDOC_OFS_PICKUP: s_d.rdata = zext(s_q.pickup);
        VDOC_OFS_ULOW: s_d.rdata = zext(s_q.u_low);
        VDOC_OFS_UHIGH: s_d.rdata = zext(s_q.u_high);
        VDOC_OFS_FLOOR: s_d.rdata[7:0] = s_q.floor_pct;
        VDOC_OFS_DELAY: s_d.rdata = s_q.delay;
        VDOC_OFS_STATUS: begin
          s_d.rdata[VDOC_ST_START_LSB +: 3] = s_q.start;
          s_d.rdata[VDOC_ST_GSTART_BIT] = s_q.gstart;
          s_d.rdata[VDOC_ST_TRIP_BIT] = s_q.trip;
          s_d.rdata[VDOC_ST_ERR_BIT] = s_q.err;
          s_d.rdata[VDOC_ST_BLOCK_BIT] = user_block || vts_block;
        end
        VDOC_OFS_IRQ_STAT: s_d.rdata[VDOC_IRQ_W-1:0] = s_q.irq_stat;
        VDOC_OFS_IRQ_EN: s_d.rdata[VDOC_IRQ_W-1:0] = s_q.irq_en;
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
      s_q.en <= VDOC_RST_EN;
      s_q.mode <= VDOC_RST_MODE;
      s_q.floor_pct <= VDOC_RST_FLOOR;
      s_q.delay <= VDOC_RST_DELAY;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign start_ph = s_q.start;
  assign gen_start = s_q.gstart;
  assign gen_trip = s_q.trip;
  assign setting_err = s_q.err;
  assign irq = s_q.irq;

endmodule

//--- core/vdoc_pkg.sv
// Purpose: constants shared by the voltage dependent overcurrent block
// Assumes: 32-bit register port, byte addresses, one word per register
// Notes: magnitudes are unsigned, same scale for all three phases
package vdoc_pkg;

  localparam logic [7:0] VDOC_OFS_CTRL = 8'h00;
  localparam logic [7:0] VDOC_OFS_PICKUP = 8'h04;
  localparam logic [7:0] VDOC_OFS_ULOW = 8'h08;
  localparam logic [7:0] VDOC_OFS_UHIGH = 8'h0C;
  localparam logic [7:0] VDOC_OFS_FLOOR = 8'h10;
  localparam logic [7:0] VDOC_OFS_DELAY = 8'h14;
  localparam logic [7:0] VDOC_OFS_STATUS = 8'h18;
  localparam logic [7:0] VDOC_OFS_IRQ_STAT = 8'h1C;
  localparam logic [7:0] VDOC_OFS_IRQ_EN = 8'h20;
  localparam logic [7:0] VDOC_OFS_IRQ_CLR = 8'h24;

  // control register fields
  localparam int VDOC_CTRL_EN_BIT = 0;
  localparam int VDOC_CTRL_MODE_BIT = 1;

  // status register fields
  localparam int VDOC_ST_START_LSB = 0;
  localparam int VDOC_ST_GSTART_BIT = 3;
  localparam int VDOC_ST_TRIP_BIT = 4;
  localparam int VDOC_ST_ERR_BIT = 5;
  localparam int VDOC_ST_BLOCK_BIT = 6;

  // interrupt event bits
  localparam int VDOC_IRQ_W = 3;
  localparam int VDOC_EV_START_BIT = 0;
  localparam int VDOC_EV_TRIP_BIT = 1;
  localparam int VDOC_EV_ERR_BIT = 2;

  // reset values
  localparam logic VDOC_RST_EN = 1'b0;
  localparam logic VDOC_RST_MODE = 1'b0;
  localparam logic [7:0] VDOC_RST_FLOOR = 8'h64;
  localparam logic [31:0] VDOC_RST_DELAY = 32'h0000_0000;

  // the floor setting is a percentage of pickup
  localparam int VDOC_PERCENT = 100;

  typedef enum logic {
    VDOC_MODE_GATED,
    VDOC_MODE_SCALED
  } vdoc_mode_t;

endpackage

//--- core/vdoc_phase.sv
// Purpose: start condition of one phase
// Assumes: floor already limited to pickup by the caller
// Notes: purely combinational, registered by the top
`timescale 1ns/1ps
module vdoc_phase
  import vdoc_pkg::*;
#(
  parameter int W = 16
) (
  // settings
  input wire logic mode,
  input wire logic [W-1:0] pickup,
  input wire logic [W-1:0] floor_thr,
  input wire logic [W-1:0] u_low,
  input wire logic [W-1:0] u_high,
  // measurement
  input wire logic [W-1:0] cur,
  input wire logic [W-1:0] volt,
  // decision
  output logic start_cond
);

  logic [W-1:0] thr;
  logic [2*W-1:0] prod;
  logic [W-1:0] span;

  always_comb begin
    span = u_high - u_low;
    prod = (2*W)'(pickup - floor_thr) * (2*W)'(volt - u_low);
    if (volt >= u_high) begin
      thr = pickup;
    end else if (volt < u_low) begin
      thr = floor_thr;
    end else begin
      // span is never zero here since low <= volt < high
      thr = floor_thr + W'(prod / (2*W)'(span));
    end
    if (mode == VDOC_MODE_GATED) begin
      start_cond = (volt < u_low) && (cur > pickup);
    end else begin
      start_cond = cur > thr;
    end
  end

endmodule

//--- tb/vdoc_checker.sv
// Purpose: port checks of vdoc_top
// Assumes: all decision outputs registered
// Notes: enable bit and irq masks are internal, so left to the bench
`timescale 1ns/1ps
module vdoc_checker (
  // watched ports
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic user_block,
  input wire logic vts_block,
  input wire logic [2:0] start_ph,
  input wire logic gen_start,
  input wire logic gen_trip,
  input wire logic setting_err
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  gen_or_a: assert property (gen_start == |start_ph) else $error("general start not or");
  user_stop_a: assert property (user_block |=> !gen_start && !gen_trip) else $error("user block");
  vts_stop_a: assert property (vts_block |=> start_ph == 3'h0 && !gen_trip) else $error("vts block");
  err_stop_a: assert property (setting_err |-> !gen_start && !gen_trip) else $error("error start");
  trip_start_a: assert property (gen_trip |-> gen_start) else $error("trip alone");
  trip_drop_a: assert property ($fell(gen_start) |-> !gen_trip) else $error("trip stays");
  rise_cause_a: assert property ($rose(gen_start) |-> !$past(user_block) && !$past(vts_block))
    else $error("start while blocked");
  read_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("stray read data");
endmodule
bind vdoc_top vdoc_checker vdoc_checker_inst (.*);

//--- tb/vdoc_meas.sv
// Purpose: measurement channel model for three phases
// Assumes: one fresh magnitude each core_clk
// Notes: all phases carry cur_cmd; unselected voltages sit at full scale
`timescale 1ns/1ps
module vdoc_meas (
  // control
  input wire logic core_clk,
  input wire logic [2:0] sel,
  input wire logic [15:0] cur_cmd,
  input wire logic [15:0] volt_cmd,
  // magnitudes
  output logic [15:0] cur_l1,
  output logic [15:0] cur_l2,
  output logic [15:0] cur_l3,
  output logic [15:0] volt_l12,
  output logic [15:0] volt_l23,
  output logic [15:0] volt_l31
);
  // equal currents expose any wrong current/voltage pairing
  always_ff @(posedge core_clk) begin
    cur_l1 <= cur_cmd;
    cur_l2 <= cur_cmd;
    cur_l3 <= cur_cmd;
    volt_l12 <= sel[0] ? volt_cmd : 16'hFFFF;
    volt_l23 <= sel[1] ? volt_cmd : 16'hFFFF;
    volt_l31 <= sel[2] ? volt_cmd : 16'hFFFF;
  end
endmodule

//--- tb/vdoc_top_tb.sv
// Purpose: self-checking bench for vdoc_top
// Assumes: pickup 1000, limits 256/512, floor 50 percent
// Notes: thresholds worked out by hand from those settings
`timescale 1ns/1ps
module vdoc_top_tb;
  import vdoc_pkg::*;
  logic core_clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, user_block = 0, vts_block = 0;
  logic gen_start, gen_trip, setting_err, irq;
  logic [7:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0, reg_rdata;
  logic [2:0] sel = 7, start_ph;
  logic [15:0] cur_cmd = 0, volt_cmd = 0, cur_l1, cur_l2, cur_l3, volt_l12, volt_l23, volt_l31;
  int fail_count = 0, tests_run = 0, cyc = 0;
  always #10 core_clk = ~core_clk;
  vdoc_meas vdoc_meas_inst (.*);
  vdoc_top vdoc_top_inst (.*);
  task automatic ck(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1;
    @(posedge core_clk);
    reg_wr <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1;
    @(posedge core_clk);
    reg_rd <= 0;
    #1 ck("reg_rdata", e, reg_rdata);
  endtask
  // model adds one cycle, the decision one more
  task automatic ap(input logic [15:0] c, input logic [15:0] v, input logic [2:0] e);
    @(posedge core_clk);
    cur_cmd <= c;
    volt_cmd <= v;
    repeat (3) @(posedge core_clk);
    #1 ck("start_ph", e, start_ph);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      report_and_stop;
    end
  end
  initial begin
    repeat (5) @(posedge core_clk);
    arst_n <= 1;
    rd(VDOC_OFS_FLOOR, 32'h64);
    rd(8'h30, 32'h0);
    wr(VDOC_OFS_PICKUP, 32'h3E8);
    wr(VDOC_OFS_ULOW, 32'h100);
    wr(VDOC_OFS_UHIGH, 32'h200);
    wr(VDOC_OFS_FLOOR, 32'h32);
    wr(VDOC_OFS_DELAY, 32'h3);
    ap(16'h3E9, 16'h0FF, 3'h0);
    wr(VDOC_OFS_CTRL, 32'h1);
    ap(16'h3E9, 16'h0FF, 3'h7);
    ap(16'h3E9, 16'h100, 3'h0);
    ap(16'h3E8, 16'h000, 3'h0);
    wr(VDOC_OFS_CTRL, 32'h3);
    ap(16'h3E9, 16'h200, 3'h7);
    ap(16'h3E8, 16'h200, 3'h0);
    ap(16'h1F5, 16'h0FF, 3'h7);
    ap(16'h1F4, 16'h0FF, 3'h0);
    ap(16'h2EF, 16'h180, 3'h7);
    ap(16'h2EE, 16'h180, 3'h0);
    for (int i = 0; i < 3; i++) begin
      sel <= 3'(1 << i);
      ap(16'h3E8, 16'h0FF, 3'(1 << i));
    end
    sel <= 7;
    wr(VDOC_OFS_ULOW, 32'h200);
    ap(16'h3E9, 16'h200, 3'h7);
    ap(16'h3E8, 16'h1FF, 3'h7);
    wr(VDOC_OFS_ULOW, 32'h201);
    ap(16'h3E9, 16'h0FF, 3'h0);
    ck("setting_err", 1, setting_err);
    wr(VDOC_OFS_ULOW, 32'h100);
    ap(16'h3E9, 16'h0FF, 3'h7);
    user_block <= 1;
    ap(16'h3E9, 16'h0FF, 3'h0);
    user_block <= 0;
    vts_block <= 1;
    ap(16'h3E9, 16'h0FF, 3'h0);
    vts_block <= 0;
    @(posedge core_clk);
    cur_cmd <= 16'h3E9;
    // start rises after this edge; trip follows three edges later
    repeat (2) @(posedge core_clk);
    #1 ck("gen_trip", 0, gen_trip);
    @(posedge core_clk);
    #1 ck("gen_trip", 1, gen_trip);
    ap(16'h0, 16'h0FF, 3'h0);
    ck("gen_trip", 0, gen_trip);
    ck("irq", 0, irq);
    rd(VDOC_OFS_IRQ_STAT, 32'h7);
    wr(VDOC_OFS_IRQ_EN, 32'h7);
    @(posedge core_clk);
    #1 ck("irq", 1, irq);
    wr(VDOC_OFS_IRQ_CLR, 32'h7);
    @(posedge core_clk);
    #1 ck("irq", 0, irq);
    rd(VDOC_OFS_IRQ_STAT, 32'h0);
    report_and_stop;
  end
endmodule
